//--- software_recovery_watchdog.sv
// Software recovery watchdog with AHB-Lite register slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module software_recovery_watchdog #(
	parameter int osc_cycles = watchdog_pkg::osc_tick_cycles
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             device_reset_request,
	output logic             watchdog_interrupt
);
	import watchdog_pkg::*;
	bus_request_type   pending;
	logic [15:0]       watchdog_reload_value;
	logic [15:0]       watchdog_current_count;
	logic [15:0]       watchdog_control;
	logic              locked;
	logic              control_written;
	logic              clear_pending;
	logic [2:0]        clear_wait;
	logic              reset_issued;
	run_state_type     state;
	run_state_type     next_state;
	wire               take;
	wire               wr;
	wire               wr_reload;
	wire               wr_control;
	wire               wr_clear;
	wire               enabled;
	wire               periodic;
	wire               irq_mode;
	wire               tick;
	wire               at_zero;
	wire               expire;
	wire               irq_busy;
	wire               service;
	wire [15:0]        status_word;
	wire [15:0]        read_word;
	wire [15:0]        next_count;
	// Single-cycle answer; the bus never stalls
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign take       = hsel && hready && htrans[1];
	assign wr         = pending.sel && pending.write;
	assign wr_reload  = wr && (pending.addr == reload_offset) && !locked;
	assign wr_control = wr && (pending.addr == control_offset) && !locked;
	assign wr_clear   = wr && (pending.addr == clear_offset) && !clear_pending;
	assign enabled    = watchdog_control[enable_bit];
	assign periodic   = watchdog_control[mode_bit];
	assign irq_mode   = watchdog_control[irq_mode_bit];
	assign at_zero    = (watchdog_current_count == 16'h0000);
	assign expire     = (state == run_count) && tick && at_zero;
	assign service    = clear_pending && (clear_wait == 3'(clear_sync_cycles - 1));
	assign status_word = {11'h000, locked, clear_pending, 2'b00, irq_busy};
	// Decoded in the address phase so the word stands for the whole data phase
	assign read_word  = (haddr == reload_offset)  ? watchdog_reload_value :
		(haddr == count_offset)   ? watchdog_current_count :
		(haddr == control_offset) ? watchdog_control :
		(haddr == status_offset)  ? status_word : 16'h0000;
	// Count down; free-running wraps back to 0x1000 rather than 0xFFFF
	assign next_count = service ? watchdog_reload_value :
		!tick ? watchdog_current_count :
		!at_zero ? watchdog_current_count - 16'h0001 :
		periodic ? watchdog_reload_value : freerun_wrap;
	assign watchdog_interrupt   = irq_busy;
	assign device_reset_request = reset_issued;
	always_comb begin
		next_state = state;
		case (state)
			run_idle:  next_state = enabled ? run_count : run_idle;
			run_count: next_state = enabled ? run_count : run_idle;
			default:   next_state = run_idle;
		endcase
	end
	watchdog_tick_divider #(
		.osc_cycles (osc_cycles)
	) u_divider (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.run      (state == run_count),
		.prescale (watchdog_control[pre_lsb +: 2]),
		.tick     (tick)
	);
	watchdog_pulse_stretch #(
		.length (irq_pulse_cycles)
	) u_irq_pulse (
		.mclk    (mclk),
		.reset_n (reset_n),
		.start   (expire && irq_mode),
		.busy    (irq_busy)
	);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pending <= '0;
		end else begin
			pending <= '{sel: take, write: hwrite, addr: haddr};
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			// A read right behind a write to the same register sees the old word
			hrdata <= {16'h0000, read_word};
		end
	end
	// Lock survives everything but reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_control <= control_reset;
			control_written  <= 1'b0;
			locked           <= 1'b0;
		end else if (wr_control) begin
			watchdog_control <= hwdata[15:0];
			control_written  <= 1'b1;
			locked           <= hwdata[enable_bit];
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_reload_value <= reload_reset;
		end else if (wr_reload) begin
			watchdog_reload_value <= hwdata[15:0];
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_current_count <= count_reset;
			state                  <= run_count;
		end else begin
			watchdog_current_count <= next_count;
			state                  <= next_state;
		end
	end
	// Crossing delay of a service write; a second write meanwhile is dropped
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clear_pending <= 1'b0;
			clear_wait    <= 3'h0;
		end else if (wr_clear) begin
			clear_pending <= 1'b1;
			clear_wait    <= 3'h0;
		end else if (service) begin
			clear_pending <= 1'b0;
		end else if (clear_pending) begin
			clear_wait <= clear_wait + 3'h1;
		end
	end
	// Reset request holds until the system reset takes this block down
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reset_issued <= 1'b0;
		end else if (expire && !irq_mode) begin
			reset_issued <= 1'b1;
		end
	end
	// needs nothing here: writing 0x00 simply clears the enable
	// without locking, which the control path above already gives.
endmodule : software_recovery_watchdog
`default_nettype wire

//--- software_recovery_watchdog_assertions.sv
// Concurrent checks on the watchdog register slave ports
`timescale 1ns/1ps
`default_nettype none
module software_recovery_watchdog_assertions import watchdog_pkg::*; (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        device_reset_request,
	input wire logic        watchdog_interrupt
);
	logic        wr_ph, rd_ph, locked, en, irq_mode;
	logic [31:0] addr_q;
	wire         take   = hsel & hready & htrans[1];
	wire         ctl_wr = wr_ph & (addr_q == control_offset) & ~locked;
	wire         rd_sta = rd_ph & (addr_q == status_offset);
	wire         rd_ctl = rd_ph & (addr_q == control_offset);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			{wr_ph, rd_ph, locked, en, irq_mode} <= 5'h02;
		end else begin
			{wr_ph, rd_ph} <= {take & hwrite, take & ~hwrite};
			locked <= locked | (ctl_wr & hwdata[enable_bit]);
			en <= ctl_wr ? hwdata[enable_bit] : en;
			irq_mode <= ctl_wr ? hwdata[irq_mode_bit] : irq_mode;
		end
	end
	// Address kept past reset on purpose; only read when a phase is flagged
	always_ff @(posedge mclk) begin
		if (take) begin
			addr_q <= haddr;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_pulse_tail;
		watchdog_interrupt ##1 !watchdog_interrupt;
	endsequence
	property p_irq_pulse;
		$rose(watchdog_interrupt) |=> s_pulse_tail;
	endproperty
	property p_reset_hold;
		device_reset_request |=> device_reset_request;
	endproperty
	property p_upper;
		rd_ph |-> hrdata[31:16] == 16'h0000;
	endproperty
	property p_lock_flag;
		rd_sta |-> hrdata[lock_status_bit] == locked;
	endproperty
	property p_enable_read;
		rd_ctl |-> hrdata[enable_bit] == en;
	endproperty
	property p_reset_mode;
		$rose(device_reset_request) |-> !irq_mode;
	endproperty
	property p_irq_mode;
		$rose(watchdog_interrupt) |-> irq_mode;
	endproperty
	property p_disabled;
		!en && !$past(en) |-> !$rose(watchdog_interrupt) && !$rose(device_reset_request);
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("interrupt pulse not two cycles");
	a_reset_hold: assert property (p_reset_hold)
		else $error("reset request dropped");
	a_upper: assert property (p_upper)
		else $error("upper read bits not zero");
	a_lock_flag: assert property (p_lock_flag)
		else $error("lock flag wrong");
	a_enable_read: assert property (p_enable_read)
		else $error("enable bit readback wrong");
	a_reset_mode: assert property (p_reset_mode)
		else $error("reset request in interrupt mode");
	a_irq_mode: assert property (p_irq_mode)
		else $error("interrupt in reset mode");
	a_disabled: assert property (p_disabled)
		else $error("expiry while disabled");
endmodule : software_recovery_watchdog_assertions
`default_nettype wire

//--- test_software_recovery_watchdog.sv
// Self-checking bench for the software recovery watchdog
`timescale 1ns/1ps
`default_nettype none
module test_software_recovery_watchdog;
	import watchdog_pkg::*;
	logic        mclk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, m_lock;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, seed = 32'h7360;
	logic [15:0] m_reload, m_ctrl, c;
	logic [1:0]  htrans = 2'h0;
	wire logic   hready, hresp, dev_rst, irq;
	wire [31:0]  hrdata;
	int          n_errors = 0, checked = 0, n, k;
	initial forever #2.5 mclk = ~mclk;
	software_recovery_watchdog #(.osc_cycles(4)) i_dut (.mclk(mclk), .reset_n(reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .device_reset_request(dev_rst), .watchdog_interrupt(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic finish_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic hold;
		n = 0;
		do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin n_errors++; finish_test(); end
	endtask : hold
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
		hold();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		hold();
		q = hrdata;
	endtask : bus
	// Model mirrors the lock: refused writes leave it untouched
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0, d});
		chk("hresp", 32'(hresp), 32'h0);
		if (!m_lock && a == reload_offset) m_reload = d;
		if (!m_lock && a == control_offset) {m_ctrl, m_lock} = {d, d[enable_bit]};
	endtask : wr
	task automatic rd(input string s, input logic [31:0] a, input logic [31:0] m, exp);
		bus(1'b0, a, 32'h0);
		chk(s, q & m, exp & m);
	endtask : rd
	task automatic wait_sig(input logic rst);
		n = 0;
		while ((rst ? dev_rst : irq) !== 1'b1 && n < 2000) begin @(posedge mclk); #1 n++; end
		if (n >= 2000) begin n_errors++; finish_test(); end
	endtask : wait_sig
	task automatic start;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		{m_reload, m_ctrl, m_lock} = {reload_reset, control_reset, 1'b0};
		rd("reload", reload_offset, 32'hFFFFFFFF, m_reload);
		rd("control", control_offset, 32'h7F, m_ctrl);
		rd("status", status_offset, 32'hFFFF, 32'h0);
	endtask : start
	initial begin
		start();
		rd("count", count_offset, 32'hFFFFFFFF, count_reset);
		rd("unmapped", 32'h40002590, 32'hFFFFFFFF, 32'h0);
		wr(control_offset, 16'h0000);
		bus(1'b0, count_offset, 32'h0);
		c = q[15:0];
		repeat (40) @(posedge mclk);
		rd("count held", count_offset, 32'hFFFF, c);
		seed = lfsr(seed);
		wr(reload_offset, {10'h0, seed[5:0]} | 16'h0010);
		rd("reload", reload_offset, 32'hFFFF, m_reload);
		wr(control_offset, 16'h0062);
		rd("lock", status_offset, 32'h10, 32'h10);
		wr(control_offset, 16'h0000);
		wr(reload_offset, 16'h0FFF);
		rd("control", control_offset, 32'h7F, m_ctrl);
		rd("reload", reload_offset, 32'hFFFF, m_reload);
		wr(clear_offset, 16'h0001);
		rd("clear pending", status_offset, 32'h8, 32'h8);
		repeat (8) @(posedge mclk);
		bus(1'b0, count_offset, 32'h0);
		c = q[15:0];
		chk("count reload", 32'(c <= m_reload && c + 16'h8 >= m_reload), 32'h1);
		wait_sig(1'b0);
		chk("expiry time", 32'(n + 8 >= 4 * c && n <= 4 * c + 12), 32'h1);
		k = 0;
		while (irq === 1'b1 && k < 10) begin @(posedge mclk); #1 k++; end
		chk("irq width", 32'(k), 32'(irq_pulse_cycles));
		chk("no reset", 32'(dev_rst), 32'h0);
		bus(1'b0, count_offset, 32'h0);
		chk("periodic", 32'(q[15:0] <= m_reload && q[15:0] + 8 >= m_reload), 32'h1);
		reset_n <= 1'b0;
		start();
		wr(reload_offset, 16'h0010);
		wr(control_offset, 16'h0026);
		wr(clear_offset, 16'h0001);
		wait_sig(1'b0);
		// Seventeen ticks of 16 x 4 cycles from the reload, plus clear and phase slack
		chk("prescale 16", 32'(n >= 1024 && n <= 1100), 32'h1);
		bus(1'b0, count_offset, 32'h0);
		chk("free run wrap", 32'(q[15:0]), 32'(freerun_wrap));
		reset_n <= 1'b0;
		start();
		wr(reload_offset, 16'h0020);
		wr(control_offset, 16'h0060);
		wr(clear_offset, 16'h0001);
		wait_sig(1'b1);
		chk("reset request", 32'(dev_rst), 32'h1);
		finish_test();
	end
endmodule : test_software_recovery_watchdog
bind software_recovery_watchdog software_recovery_watchdog_assertions i_chk (
	.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.device_reset_request(device_reset_request), .watchdog_interrupt(watchdog_interrupt));
`default_nettype wire

//--- watchdog_pkg.sv
// Package of constants, register map and types for the software recovery watchdog
`default_nettype none
package watchdog_pkg;
	localparam logic [31:0] reload_offset     = 32'h40002580;
	localparam logic [31:0] count_offset      = 32'h40002584;
	localparam logic [31:0] control_offset    = 32'h40002588;
	localparam logic [31:0] clear_offset      = 32'h4000258C;
	localparam logic [31:0] status_offset     = 32'h40002598;
	localparam logic [15:0] reload_reset      = 16'h1000;
	localparam logic [15:0] count_reset       = 16'h1000;
	localparam logic [15:0] control_reset     = 16'h00E9;
	localparam logic [15:0] freerun_wrap      = 16'h1000;
	localparam int          enable_bit        = 5;
	localparam int          mode_bit          = 6;
	localparam int          irq_mode_bit      = 1;
	localparam int          lock_status_bit   = 4;
	localparam int          irq_status_bit    = 0;
	localparam int          clear_status_bit  = 3;
	localparam int          pre_lsb           = 2;
	localparam int          osc_period_ns     = 30518;
	localparam int          clk_period_ns     = 5;
	localparam int          osc_tick_cycles   = osc_period_ns / clk_period_ns;
	localparam int          irq_pulse_cycles  = 2;
	localparam int          clear_sync_cycles = 4;
	localparam logic [11:0] div_16            = 12'h00F;
	localparam logic [11:0] div_256           = 12'h0FF;
	localparam logic [11:0] div_4096          = 12'hFFF;
	typedef struct packed {
		logic        sel;
		logic        write;
		logic [31:0] addr;
	} bus_request_type;
	typedef enum {run_idle, run_count} run_state_type;
endpackage : watchdog_pkg
`default_nettype wire

//--- watchdog_pulse_stretch.sv
// Fixed-length pulse generator
`timescale 1ns/1ps
`default_nettype none
module watchdog_pulse_stretch #(
	parameter int length = 2
) (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      busy
);
	logic [7:0] remain;
	assign busy = (remain != 8'h00);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			remain <= 8'h00;
		end else if (start) begin
			remain <= 8'(length);
		end else if (busy) begin
			remain <= remain - 8'h01;
		end
	end
endmodule : watchdog_pulse_stretch
`default_nettype wire

//--- watchdog_tick_divider.sv
// Oscillator tick generator and selectable prescaler
`timescale 1ns/1ps
`default_nettype none
module watchdog_tick_divider #(
	parameter int osc_cycles = 6103
) (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       run,
	input  wire logic [1:0] prescale,
	output logic            tick
);
	import watchdog_pkg::*;
	logic [15:0] osc_count;
	logic [11:0] pre_count;
	logic        osc_tick;
	logic [11:0] pre_limit;
	assign osc_tick  = (osc_count == 16'(osc_cycles - 1));
	assign pre_limit = (prescale == 2'h0) ? 12'h000 : (prescale == 2'h1) ? div_16 :
		(prescale == 2'h2) ? div_256 : div_4096;
	assign tick      = run && osc_tick && (pre_count == pre_limit);
	// Free-running oscillator emulation; counts at all times outside reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			osc_count <= 16'h0000;
		end else begin
			osc_count <= osc_tick ? 16'h0000 : osc_count + 16'h0001;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pre_count <= 12'h000;
		end else if (!run) begin
			pre_count <= 12'h000;
		end else if (osc_tick) begin
			pre_count <= (pre_count >= pre_limit) ? 12'h000 : pre_count + 12'h001;
		end
	end
endmodule : watchdog_tick_divider
`default_nettype wire
